// >>> fis_map.vh
// Constants for the power-switch inspection sequencer: field positions, codes and timing.
// Included by the sequencer only; holds definitions and nothing else.
`ifndef FIS_MAP_VH
`define FIS_MAP_VH

// Inspection type codes.
`define FIS_TYPE_RELAY_OFF 2'h0
`define FIS_TYPE_RELAY_ON 2'h1
`define FIS_TYPE_SIMUL 2'h2
`define FIS_TYPE_FREE 2'h3

// Comparator word bit positions: uh, ul, vh, vl, wh, wl.
`define FIS_BIT_UH 10
`define FIS_BIT_UL 8
`define FIS_BIT_VH 6
`define FIS_BIT_VL 4
`define FIS_BIT_WH 2
`define FIS_BIT_WL 0

// Expected word of the simultaneous-drive sequence at every step.
`define FIS_EXP_SIMUL 16'h0555

// Final step numbers and completion step numbers.
`define FIS_LAST_ONE_BY_ONE 4'h6
`define FIS_LAST_SHORT 4'h2
`define FIS_DONE_ONE_BY_ONE 4'h7
`define FIS_DONE_SIMUL 4'h3

// Reset values.
`define FIS_RST_STEP 4'h0
`define FIS_RST_WORD 16'h0000

// Timing: clock period, settling interval and step length in ns, and derived cycles.
`define FIS_CLK_NS 40
`define FIS_SETTLE_NS 64000
`define FIS_STEP_NS 128000
`define FIS_SETTLE_CYC ((`FIS_SETTLE_NS + `FIS_CLK_NS - 1) / `FIS_CLK_NS)
`define FIS_STEP_CYC ((`FIS_STEP_NS + `FIS_CLK_NS - 1) / `FIS_CLK_NS)

`endif

// >>> fis_sequencer.v
// Automatic power-switch inspection sequencer of a three-phase gate pre-driver.
// Assumes the register fields arrive as plain ports from the device's serial register
// logic on sys_clk, and that the filtered comparator outputs are already on sys_clk.
//
// Notes on behaviour
// - Start simultaneous-drive check on start request with type 2 and unlock high.
// - On any start, turn mid-voltage resistors on and wait settling before first step.
// - Simultaneous check compares at all-off, all-highs-on and all-lows-on steps.
// - Expected simultaneous word is 0555 at steps 0, 1 and 2.
// - First mismatch halts sequence, keeps its step number; no mismatch keeps flag low.
// - Comparator word of the mismatching step is kept, read with select low.
// - Comparator outputs are captured into results at a fixed point of each step.
// - Mid-voltage resistors stay on while an inspection runs.
// - Free-pattern check runs one pattern, sampled from control register at start.
// - Free pattern with both sides of a phase on drives that phase fully off.
// - Free-pattern check never compares nor raises mismatch; it only stores results.
// - A start request during a running inspection is ignored.
// - While running, pre-drivers follow the inspection block, not gate command pins.
// - Stop request during a step finishes that step, ends; step number shows last executed step.
// - Stop during the final step (6h or 2h) is ignored.
// - Unlock cleared ends inspection at once, even mid-step.
// - While running, raw detect always feeds filters and normal fault detection is off.
// - Without mismatch, step number ends at 7h (one-by-one) or 3h (simultaneous).
// - Running status bit is high exactly while a sequence executes.
// - Select high reads live comparator outputs; stored results are unaffected.
// - Mismatch flag and stored word clear on new start or save-clear.
`timescale 1ns/1ps
`include "fis_map.vh"

module fis_sequencer (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Register fields from the serial register logic
  input wire inspection_unlock,
  input wire [1:0] inspection_type,
  input wire start_request,
  input wire stop_request,
  input wire [5:0] inspection_control_two,
  input wire compare_readback_select,
  input wire result_save_clear,
  // Gate command pins
  input wire gate_cmd_u_high,
  input wire gate_cmd_u_low,
  input wire gate_cmd_v_high,
  input wire gate_cmd_v_low,
  input wire gate_cmd_w_high,
  input wire gate_cmd_w_low,
  // Filtered drain-source comparators
  input wire cmp_phase_u_high,
  input wire cmp_phase_u_low,
  input wire cmp_phase_v_high,
  input wire cmp_phase_v_low,
  input wire cmp_phase_w_high,
  input wire cmp_phase_w_low,
  // Pre-driver controls, order uh, ul, vh, vl, wh, wl
  output reg [5:0] gate_drive_reg,
  output reg mid_resistor_on_reg,
  output reg detect_force_enable_reg,
  output reg fault_detect_disable_reg,
  // Readable status
  output reg auto_test_running_reg,
  output reg test_mismatch_reg,
  output reg [3:0] inspection_step_number_reg,
  output reg [15:0] drain_source_compare_status_reg
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  // Reset asserts at once but is released on the clock, so no flop sees a release near its edge.
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Gate pins come from outside the clock domain; two flops keep metastability off the drive mux.
  reg [5:0] gate_meta_reg;
  reg [5:0] gate_sync_reg;
  always @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      gate_meta_reg <= 6'h00;
      gate_sync_reg <= 6'h00;
    end else begin
      gate_meta_reg <= {gate_cmd_u_high, gate_cmd_u_low, gate_cmd_v_high,
                        gate_cmd_v_low, gate_cmd_w_high, gate_cmd_w_low};
      gate_sync_reg <= gate_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Comparator word and free-pattern interlock
  // ----------------------------------------------------------------
  wire [5:0] cmp_bits = {cmp_phase_u_high, cmp_phase_u_low, cmp_phase_v_high,
                         cmp_phase_v_low, cmp_phase_w_high, cmp_phase_w_low};
  wire [15:0] cmp_word;
  assign cmp_word[15:11] = 5'h00;
  assign cmp_word[`FIS_BIT_UH] = cmp_phase_u_high;
  assign cmp_word[`FIS_BIT_UL] = cmp_phase_u_low;
  assign cmp_word[`FIS_BIT_VH] = cmp_phase_v_high;
  assign cmp_word[`FIS_BIT_VL] = cmp_phase_v_low;
  assign cmp_word[`FIS_BIT_WH] = cmp_phase_w_high;
  assign cmp_word[`FIS_BIT_WL] = cmp_phase_w_low;
  assign cmp_word[9] = 1'b0;
  assign cmp_word[7] = 1'b0;
  assign cmp_word[5] = 1'b0;
  assign cmp_word[3] = 1'b0;
  assign cmp_word[1] = 1'b0;

  // A phase with both switches requested would short its bridge leg, so both are dropped.
  wire [5:0] free_safe;
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
      wire both_on = inspection_control_two[2*ph+1] & inspection_control_two[2*ph];
      assign free_safe[2*ph+1] = inspection_control_two[2*ph+1] & ~both_on;
      assign free_safe[2*ph] = inspection_control_two[2*ph] & ~both_on;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_STEP = 3'b100;
  // The timer is twelve bits wide, which covers the longest interval of a step.
  localparam integer SETTLE_LAST_INT = `FIS_SETTLE_CYC - 1;
  localparam integer STEP_LAST_INT = `FIS_STEP_CYC - 1;
  localparam [11:0] SETTLE_LAST = SETTLE_LAST_INT[11:0];
  localparam [11:0] STEP_LAST = STEP_LAST_INT[11:0];
  localparam [15:0] EXP_SIMUL = `FIS_EXP_SIMUL;

  reg [2:0] state_reg;
  reg [11:0] timer_reg;
  reg [1:0] type_reg;
  reg [5:0] free_reg;
  reg stop_pending_reg;
  reg [15:0] saved_word_reg;

  wire [3:0] step = inspection_step_number_reg;
  wire one_by_one = (type_reg == `FIS_TYPE_RELAY_OFF) || (type_reg == `FIS_TYPE_RELAY_ON);
  wire [3:0] last_step = one_by_one ? `FIS_LAST_ONE_BY_ONE : `FIS_LAST_SHORT;
  wire running = (state_reg != ST_IDLE);
  wire step_end = (state_reg == ST_STEP) && (timer_reg == STEP_LAST);

  // Drive pattern and expected comparator bits for the current step.
  reg [5:0] step_drive;
  reg [5:0] step_expect;
  always @* begin
    step_drive = 6'h00;
    step_expect = 6'h3f;
    case (type_reg)
      `FIS_TYPE_SIMUL: begin
        if (step == 4'h1) begin
          step_drive = 6'h2a;
        end else if (step == 4'h2) begin
          step_drive = 6'h15;
        end
        step_expect = {EXP_SIMUL[`FIS_BIT_UH], EXP_SIMUL[`FIS_BIT_UL],
                       EXP_SIMUL[`FIS_BIT_VH], EXP_SIMUL[`FIS_BIT_VL],
                       EXP_SIMUL[`FIS_BIT_WH], EXP_SIMUL[`FIS_BIT_WL]};
      end
      `FIS_TYPE_FREE: begin
        if (step != 4'h0) begin
          step_drive = free_reg;
        end
      end
      default: begin
        // One-by-one types drive no switch at step 0 and a single switch at each of steps 1 to 6, high sides first.
        case (step)
          4'h1: step_drive = 6'h20;
          4'h2: step_drive = 6'h08;
          4'h3: step_drive = 6'h02;
          4'h4: step_drive = 6'h10;
          4'h5: step_drive = 6'h04;
          4'h6: step_drive = 6'h01;
          default: step_drive = 6'h00;
        endcase
        if (type_reg == `FIS_TYPE_RELAY_OFF) begin
          step_expect = ~step_drive;
        end else if (step == 4'h0) begin
          step_expect = 6'h3f;
        end else if (step <= 4'h3) begin
          step_expect = 6'h15;
        end else begin
          step_expect = 6'h2a;
        end
      end
    endcase
  end

  // The free-pattern type never compares, so it cannot raise the flag.
  wire mismatch = step_end && (type_reg != `FIS_TYPE_FREE) && (cmp_bits != step_expect);
  wire start_ok = !running && start_request && inspection_unlock;

  always @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= ST_IDLE;
      timer_reg <= 12'h000;
      type_reg <= `FIS_TYPE_RELAY_OFF;
      free_reg <= 6'h00;
      stop_pending_reg <= 1'b0;
      inspection_step_number_reg <= `FIS_RST_STEP;
      test_mismatch_reg <= 1'b0;
      saved_word_reg <= `FIS_RST_WORD;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Type and pattern are latched here, so later register writes cannot alter a run.
          if (start_ok) begin
            state_reg <= ST_SETTLE;
            timer_reg <= 12'h000;
            type_reg <= inspection_type;
            free_reg <= free_safe;
            stop_pending_reg <= 1'b0;
            inspection_step_number_reg <= 4'h0;
          end
        end
        ST_SETTLE: begin
          if (timer_reg == SETTLE_LAST) begin
            state_reg <= ST_STEP;
            timer_reg <= 12'h000;
          end else begin
            timer_reg <= timer_reg + 12'h001;
          end
        end
        ST_STEP: begin
          // A stop is remembered until the step ends, so the step in progress always completes.
          if (stop_request && step != last_step) begin
            stop_pending_reg <= 1'b1;
          end
          if (step_end) begin
            timer_reg <= 12'h000;
            if (mismatch || stop_pending_reg || (stop_request && (step != last_step))) begin
              state_reg <= ST_IDLE;
            end else if (step == last_step) begin
              state_reg <= ST_IDLE;
              inspection_step_number_reg <= step + 4'h1;
            end else begin
              inspection_step_number_reg <= step + 4'h1;
            end
          end else begin
            timer_reg <= timer_reg + 12'h001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // Losing the unlock abandons the sequence wherever it stands.
      if (running && !inspection_unlock) begin
        state_reg <= ST_IDLE;
      end
      // A capture at a step end wins over a clear in the same cycle.
      if (start_ok || result_save_clear) begin
        test_mismatch_reg <= 1'b0;
        saved_word_reg <= `FIS_RST_WORD;
      end
      // Capture sits on the last cycle of a step, when the filtered comparators have settled longest.
      if (step_end && inspection_unlock) begin
        saved_word_reg <= cmp_word;
        if (mismatch) begin
          test_mismatch_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      gate_drive_reg <= 6'h00;
      mid_resistor_on_reg <= 1'b0;
      detect_force_enable_reg <= 1'b0;
      fault_detect_disable_reg <= 1'b0;
      auto_test_running_reg <= 1'b0;
      drain_source_compare_status_reg <= `FIS_RST_WORD;
    end else begin
      // Settling drives nothing; the gate pins regain control only once the run has ended.
      gate_drive_reg <= running ? ((state_reg == ST_STEP) ? step_drive : 6'h00) : gate_sync_reg;
      mid_resistor_on_reg <= running;
      detect_force_enable_reg <= running;
      fault_detect_disable_reg <= running;
      auto_test_running_reg <= running;
      drain_source_compare_status_reg <= compare_readback_select ? cmp_word : saved_word_reg;
    end
  end

endmodule

// >>> fis_seq_asserts.sv
// Assertions on the ports of the power-switch inspection sequencer.
// Assumes a single sys_clk domain; bound to every sequencer instance below.
`timescale 1ns/1ps
module fis_seq_asserts (
  // Clock, reset and register fields
  input wire sys_clk,
  input wire rst_b,
  input wire inspection_unlock,
  input wire start_request,
  input wire compare_readback_select,
  input wire result_save_clear,
  // Filtered comparators
  input wire cmp_phase_u_high,
  input wire cmp_phase_u_low,
  input wire cmp_phase_v_high,
  input wire cmp_phase_v_low,
  input wire cmp_phase_w_high,
  input wire cmp_phase_w_low,
  // Sequencer outputs
  input wire [5:0] gate_drive_reg,
  input wire mid_resistor_on_reg,
  input wire auto_test_running_reg,
  input wire test_mismatch_reg,
  input wire [3:0] inspection_step_number_reg,
  input wire [15:0] drain_source_compare_status_reg
);
  wire [15:0] live_word = {5'h00, cmp_phase_u_high, 1'h0, cmp_phase_u_low, 1'h0, cmp_phase_v_high, 1'h0,
    cmp_phase_v_low, 1'h0, cmp_phase_w_high, 1'h0, cmp_phase_w_low};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_start_answer: assert property ($rose(auto_test_running_reg) |-> $past(start_request, 2))
    else $error("running rose without a start two cycles before");
  a_settle_all_off: assert property ($rose(auto_test_running_reg) |-> (gate_drive_reg == 6'h00) [*8])
    else $error("pre-drivers driven during settling");
  a_mid_while_run: assert property (auto_test_running_reg |-> mid_resistor_on_reg)
    else $error("mid-voltage resistors off during a run");
  a_phase_interlock: assert property (auto_test_running_reg |->
    (gate_drive_reg & {gate_drive_reg[4:0], 1'h0} & 6'h2a) == 6'h00)
    else $error("both switches of one phase driven");
  a_mismatch_halts: assert property ($rose(test_mismatch_reg) |-> ##[0:2] !auto_test_running_reg)
    else $error("sequence kept running after a mismatch");
  a_unlock_aborts: assert property (!inspection_unlock |-> ##2 !auto_test_running_reg)
    else $error("run survived unlock low");
  a_step_idle_hold: assert property ($changed(inspection_step_number_reg) && !$past(auto_test_running_reg)
    |-> ##[0:1] auto_test_running_reg)
    else $error("step number moved while idle");
  a_live_readback: assert property (compare_readback_select |=> drain_source_compare_status_reg ==
    $past(live_word))
    else $error("status does not show live comparators");
  a_clear_flag: assert property (result_save_clear && !auto_test_running_reg |=> !test_mismatch_reg)
    else $error("mismatch flag survived save-clear");
endmodule
bind fis_sequencer fis_seq_asserts u_chk (.sys_clk, .rst_b, .inspection_unlock, .start_request,
  .compare_readback_select, .result_save_clear, .cmp_phase_u_high, .cmp_phase_u_low, .cmp_phase_v_high,
  .cmp_phase_v_low, .cmp_phase_w_high, .cmp_phase_w_low, .gate_drive_reg, .mid_resistor_on_reg,
  .auto_test_running_reg, .test_mismatch_reg, .inspection_step_number_reg, .drain_source_compare_status_reg);

// >>> fis_bridge_model.sv
// Behavioural bridge and filtered comparator stage facing the pre-drivers.
// Assumes healthy switches at mid-voltage read high; the bench sets fault_mask bits to inject faults.
`timescale 1ns/1ps
module fis_bridge_model (
  // Fault injection, order uh, ul, vh, vl, wh, wl
  input wire [5:0] fault_mask,
  // Filtered comparator outputs, same order
  output wire [5:0] cmp
);
  // Relays are taken as set for normal operation, with an alarm stopping only the pre-drivers.
  assign cmp = ~fault_mask;
endmodule

// >>> test_fis_sequencer.sv
// Self-checking bench for the inspection sequencer.
// Assumes the bridge model and the bound checker are compiled before it.
`timescale 1ns/1ps
module test_fis_sequencer;
  reg sys_clk, rst_b, unlock, start, stop, sel, clr;
  reg [1:0] typ;
  reg [5:0] pattern, fault, gcmd;
  wire [5:0] cmp, drive;
  wire mid, det, fdis, run, err;
  wire [3:0] step;
  wire [15:0] stat;
  integer mismatches, comparisons, cycles;
  fis_bridge_model bridge (.fault_mask(fault), .cmp(cmp));
  fis_sequencer dut (.sys_clk(sys_clk), .rst_b(rst_b), .inspection_unlock(unlock), .inspection_type(typ),
    .start_request(start), .stop_request(stop), .inspection_control_two(pattern), .compare_readback_select(sel),
    .result_save_clear(clr), .gate_cmd_u_high(gcmd[5]), .gate_cmd_u_low(gcmd[4]), .gate_cmd_v_high(gcmd[3]),
    .gate_cmd_v_low(gcmd[2]), .gate_cmd_w_high(gcmd[1]), .gate_cmd_w_low(gcmd[0]), .cmp_phase_u_high(cmp[5]),
    .cmp_phase_u_low(cmp[4]), .cmp_phase_v_high(cmp[3]), .cmp_phase_v_low(cmp[2]), .cmp_phase_w_high(cmp[1]),
    .cmp_phase_w_low(cmp[0]), .gate_drive_reg(drive), .mid_resistor_on_reg(mid), .detect_force_enable_reg(det),
    .fault_detect_disable_reg(fdis), .auto_test_running_reg(run), .test_mismatch_reg(err),
    .inspection_step_number_reg(step), .drain_source_compare_status_reg(stat));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task go(input is_stop);
    begin
      @(negedge sys_clk);
      if (is_stop) stop = 1; else start = 1;
      @(negedge sys_clk);
      stop = 0;
      start = 0;
    end
  endtask
  // The step number reads zero during settling too, so this returns before the first drive step.
  task wait_step(input [3:0] n);
    while (!(run === 1'b1 && step === n)) @(negedge sys_clk);
  endtask
  task launch(input [1:0] t);
    begin
      typ = t;
      go(0);
      wait_step(0);
    end
  endtask
  task read_stat(input s, input [15:0] exp);
    begin
      sel = s;
      repeat (2) @(negedge sys_clk);
      check(stat, exp);
    end
  endtask
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  // A run that never ends is cut short here rather than hanging the simulator.
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 70000) begin
      mismatches = mismatches + 1;
      final_report;
    end
  end
  initial begin
    {rst_b, unlock, start, stop, sel, clr} = 6'h00;
    {typ, pattern, fault} = 14'h0000;
    gcmd = 6'h00;
    {mismatches, comparisons, cycles} = 96'h0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1;
    repeat (4) @(negedge sys_clk);
    unlock = 1;
    launch(2'h2);
    wait_step(1);
    repeat (4) @(negedge sys_clk);
    check(drive, 6'h2a);
    check({det, fdis}, 2'h3);
    check(mid, 1'h1);
    go(0);
    repeat (4) @(negedge sys_clk);
    check(step, 4'h1);
    wait_step(2);
    repeat (4) @(negedge sys_clk);
    check(drive, 6'h15);
    go(1);
    while (run !== 1'b0) @(negedge sys_clk);
    check(step, 4'h3);
    check(err, 1'h0);
    read_stat(0, 16'h0555);
    $display("Test simultaneous pass done");
    launch(2'h2);
    wait_step(1);
    fault = 6'h20;
    while (run !== 1'b0) @(negedge sys_clk);
    check(step, 4'h1);
    check(err, 1'h1);
    read_stat(0, 16'h0155);
    fault = 6'h00;
    read_stat(1, 16'h0555);
    read_stat(0, 16'h0155);
    clr = 1;
    @(negedge sys_clk);
    clr = 0;
    read_stat(0, 16'h0000);
    check(err, 1'h0);
    $display("Test mismatch done");
    pattern = 6'h38;
    fault = 6'h2a;
    launch(2'h3);
    pattern = 6'h00;
    wait_step(1);
    repeat (4) @(negedge sys_clk);
    check(drive, 6'h08);
    while (run !== 1'b0) @(negedge sys_clk);
    check(step, 4'h3);
    check(err, 1'h0);
    read_stat(0, 16'h0111);
    fault = 6'h00;
    $display("Test free pattern done");
    launch(2'h1);
    repeat (1700) @(negedge sys_clk);
    go(1);
    repeat (4) @(negedge sys_clk);
    check(run, 1'h1);
    while (run !== 1'b0) @(negedge sys_clk);
    check(step, 4'h0);
    check(err, 1'h0);
    $display("Test stop done");
    fault = 6'h01;
    launch(2'h0);
    while (run !== 1'b0) @(negedge sys_clk);
    check(step, 4'h0);
    check(err, 1'h1);
    read_stat(0, 16'h0554);
    fault = 6'h00;
    $display("Test one-by-one mismatch done");
    launch(2'h2);
    wait_step(1);
    unlock = 0;
    repeat (3) @(negedge sys_clk);
    check(run, 1'h0);
    check(drive, 6'h00);
    gcmd = 6'h21;
    repeat (4) @(negedge sys_clk);
    check(drive, 6'h21);
    gcmd = 6'h00;
    unlock = 1;
    $display("Test abort done");
    final_report;
  end
endmodule
